// ### shared/acsr_pkg.sv
/*
  Constants and carrier types for the converter status and result register block.
  Assumes a 32-bit plain register port with byte offsets and a single 100 MHz clock.
*/
package acsr_pkg;

  // ==========================================================================
  // Register offsets
  // ==========================================================================
  localparam logic [7:0] OFF_CHAN_ENABLED = 8'h18;
  localparam logic [7:0] OFF_FLAG_STATUS = 8'h1C;
  localparam logic [7:0] OFF_LATEST_RESULT = 8'h20;
  localparam logic [7:0] OFF_IRQ_SET_ENABLE = 8'h24;
  localparam logic [7:0] OFF_IRQ_CLEAR_ENABLE = 8'h28;
  localparam logic [7:0] OFF_IRQ_ENABLE_READBACK = 8'h2C;
  localparam logic [7:0] OFF_CHAN_RESULT_BASE = 8'h30;
  localparam logic [7:0] OFF_CHAN_RESULT_LAST = 8'h4C;
  localparam logic [7:0] OFF_DMA_RECEIVE_COUNTER = 8'h50;
  localparam logic [7:0] OFF_DMA_NEXT_RECEIVE_COUNTER = 8'h54;

  // ==========================================================================
  // Field layout
  // ==========================================================================
  localparam int NUM_CHANNELS = 8;
  localparam int RESULT_WIDTH = 10;
  localparam int COUNT_WIDTH = 16;
  localparam int FLAG_WIDTH = 20;
  localparam int POS_DONE = 0;
  localparam int POS_OVERRUN = 8;
  localparam int POS_DATA_VALID = 16;
  localparam int POS_ANY_OVERRUN = 17;
  localparam int POS_COUNT_DONE = 18;
  localparam int POS_BUFFERS_EXHAUSTED = 19;

  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [FLAG_WIDTH-1:0] RESET_FLAGS = 20'h0_0000;
  localparam logic [RESULT_WIDTH-1:0] RESET_RESULT = 10'h000;
  localparam logic [COUNT_WIDTH-1:0] RESET_COUNT = 16'h0000;
  localparam logic [COUNT_WIDTH-1:0] COUNT_ZERO = 16'h0000;
  localparam logic [COUNT_WIDTH-1:0] COUNT_ONE = 16'h0001;

  // ==========================================================================
  // Carrier types
  // ==========================================================================
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic write;
    logic read;
  } acsr_bus_t;

  typedef struct packed {
    logic done;
    logic [2:0] channel;
    logic [RESULT_WIDTH-1:0] value;
  } acsr_conv_t;

  typedef struct packed {
    logic transfer;
  } acsr_dma_t;

endpackage

// ### hw/acsr_status_regs.sv
/*
  Status, result and interrupt register logic of an eight-channel converter controller.
  Assumes the converter core delivers one-cycle done pulses with channel and value, a channel
  enable vector from the channel control registers, and a DMA engine that pulses per transfer.
*/
// Chosen here: the register offsets and the strobed register port.
// Behaviour
// R01 - Channel readback bit shows channel enabled state
// R02 - Done flag set only for enabled finished channel
// R03 - Channel overrun sticky, cleared by status read
// R04 - Data valid set on conversion, cleared reading result
// R05 - Any overrun sticky, cleared by status read
// R06 - Count done on zero, cleared by counter write
// R07 - Buffers exhausted while both counters zero
// R08 - Latest result captures every conversion value
// R09 - Channel result loads only when channel enabled
// R10 - Enable write ones set mask bits
// R11 - Disable write ones clear mask bits
// R12 - Mask readback shows enabled sources
// R13 - Interrupt registers share status bit layout
// R14 - Software never disables channel mid-conversion
// R15 - Interrupt high while unmasked flag set
// R16 - Unused bits read zero, writes ignored
`timescale 1ns/100ps

module acsr_status_regs
  import acsr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire acsr_pkg::acsr_bus_t bus,
  output logic [31:0] rdata,
  input wire logic [7:0] chanEnabled,
  input wire acsr_pkg::acsr_conv_t conv,
  input wire logic overrunGeneral,
  input wire acsr_pkg::acsr_dma_t dma,
  output logic irq
);
  import acsr_pkg::*;

  typedef enum logic [1:0] {
    CNT_IDLE = 2'b00,
    CNT_ACTIVE = 2'b01,
    CNT_DRAINED = 2'b10
  } acsr_cnt_state_t;

  logic [7:0] doneFlag_q;
  logic [7:0] chanOverrun_q;
  logic dataValid_q;
  logic anyOverrun_q;
  logic countDone_q;
  logic [FLAG_WIDTH-1:0] mask_q;
  logic [RESULT_WIDTH-1:0] latest_q;
  logic [RESULT_WIDTH-1:0] chanResult_q [NUM_CHANNELS];
  logic [COUNT_WIDTH-1:0] rxCount_q;
  logic [COUNT_WIDTH-1:0] rxNext_q;
  acsr_cnt_state_t cntState_q;
  logic [FLAG_WIDTH-1:0] flags;
  logic [7:0] convHit;
  logic statusRead;
  logic latestRead;
  logic cntWrite;
  logic rcrWrite;
  logic rnrWrite;
  logic setWrite;
  logic clrWrite;
  logic reachZero;
  logic [31:0] rdata_d;
  acsr_cnt_state_t cntState_d;

  // Returns true when a bus access of the given kind targets the given offset.
  function automatic logic hit(input acsr_bus_t b, input logic kind, input logic [7:0] off);
    hit = kind && (b.addr == off);
  endfunction

  // Returns true when a byte address falls on one of the word-aligned result registers.
  function automatic logic inResultWindow(input logic [7:0] addr);
    inResultWindow = (addr >= OFF_CHAN_RESULT_BASE) && (addr <= OFF_CHAN_RESULT_LAST)
      && (addr[1:0] == 2'b00);
  endfunction

  // ==========================================================================
  // Access decode
  // ==========================================================================
  assign statusRead = hit(bus, bus.read, OFF_FLAG_STATUS);
  assign latestRead = hit(bus, bus.read, OFF_LATEST_RESULT);
  assign rcrWrite = hit(bus, bus.write, OFF_DMA_RECEIVE_COUNTER);
  assign rnrWrite = hit(bus, bus.write, OFF_DMA_NEXT_RECEIVE_COUNTER);
  assign setWrite = hit(bus, bus.write, OFF_IRQ_SET_ENABLE);
  assign clrWrite = hit(bus, bus.write, OFF_IRQ_CLEAR_ENABLE);
  assign cntWrite = rcrWrite || rnrWrite;
  assign convHit = conv.done ? (8'h01 << conv.channel) : 8'h00;

  // ==========================================================================
  // Per-channel flags
  // ==========================================================================
  // A done flag is dropped as soon as its channel is disabled.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      doneFlag_q <= 8'h00;
    end
    else
    begin
      doneFlag_q <= (doneFlag_q | (convHit & chanEnabled)) & chanEnabled; // R02 R14
    end
  end

  // Overrun is a new result on an enabled channel whose done flag is already set.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      chanOverrun_q <= 8'h00;
    end
    else
    begin
      chanOverrun_q <= (statusRead ? 8'h00 : chanOverrun_q)
        | (convHit & chanEnabled & doneFlag_q); // R03
    end
  end

  // ==========================================================================
  // General flags
  // ==========================================================================
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dataValid_q <= 1'b0;
    end
    else
    begin
      dataValid_q <= conv.done || (dataValid_q && !latestRead); // R04
    end
  end

  // A new result while the previous one is still unread also counts as a general overrun.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      anyOverrun_q <= 1'b0;
    end
    else
    begin
      anyOverrun_q <= overrunGeneral || (dataValid_q && conv.done)
        || (anyOverrun_q && !statusRead); // R05
    end
  end

  // ==========================================================================
  // Results
  // ==========================================================================
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      latest_q <= RESET_RESULT;
    end
    else if (conv.done)
    begin
      latest_q <= conv.value; // R08
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_CHANNELS; i++)
      begin
        chanResult_q[i] <= RESET_RESULT;
      end
    end
    else
    begin
      for (int i = 0; i < NUM_CHANNELS; i++)
      begin
        if (convHit[i] && chanEnabled[i])
        begin
          chanResult_q[i] <= conv.value; // R09
        end
      end
    end
  end

  // ==========================================================================
  // DMA receive counters
  // ==========================================================================
  // Each transfer decrements a current count above one; a transfer at a count of one promotes the next count instead.
  assign reachZero = dma.transfer && (rxCount_q == COUNT_ONE);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rxCount_q <= RESET_COUNT;
    end
    else if (rcrWrite)
    begin
      rxCount_q <= bus.wdata[COUNT_WIDTH-1:0];
    end
    else if (!rnrWrite && reachZero)
    begin
      rxCount_q <= rxNext_q;
    end
    else if (!rnrWrite && dma.transfer && (rxCount_q != COUNT_ZERO))
    begin
      rxCount_q <= rxCount_q - COUNT_ONE;
    end
  end

  // A counter write takes priority over a transfer, so no promotion happens in that cycle.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rxNext_q <= RESET_COUNT;
    end
    else if (rnrWrite)
    begin
      rxNext_q <= bus.wdata[COUNT_WIDTH-1:0];
    end
    else if (!rcrWrite && reachZero)
    begin
      rxNext_q <= COUNT_ZERO;
    end
  end

  // Reaching zero in the same cycle as a counter write keeps the tracker drained.
  always_comb
  begin
    cntState_d = cntState_q;
    case (cntState_q)
      CNT_IDLE: cntState_d = reachZero ? CNT_DRAINED : cntWrite ? CNT_ACTIVE : CNT_IDLE;
      CNT_ACTIVE: cntState_d = reachZero ? CNT_DRAINED : CNT_ACTIVE;
      CNT_DRAINED: cntState_d = (cntWrite && !reachZero) ? CNT_ACTIVE : CNT_DRAINED;
      default: cntState_d = CNT_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cntState_q <= CNT_IDLE;
    end
    else
    begin
      cntState_q <= cntState_d;
    end
  end

  // The count-done flag is the drained state of the counter tracker.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      countDone_q <= 1'b0;
    end
    else
    begin
      countDone_q <= (cntState_d == CNT_DRAINED); // R06
    end
  end

  // ==========================================================================
  // Interrupt mask
  // ==========================================================================
  // Set and clear sit at different offsets, so they never meet in one cycle.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mask_q <= RESET_FLAGS;
    end
    else if (setWrite)
    begin
      mask_q <= mask_q | bus.wdata[FLAG_WIDTH-1:0]; // R10 R13 R16
    end
    else if (clrWrite)
    begin
      mask_q <= mask_q & ~bus.wdata[FLAG_WIDTH-1:0]; // R11 R13 R16
    end
  end

  // ==========================================================================
  // Status assembly and read-back
  // ==========================================================================
  always_comb
  begin
    flags = RESET_FLAGS;
    flags[POS_DONE +: NUM_CHANNELS] = doneFlag_q; // R13
    flags[POS_OVERRUN +: NUM_CHANNELS] = chanOverrun_q;
    flags[POS_DATA_VALID] = dataValid_q;
    flags[POS_ANY_OVERRUN] = anyOverrun_q;
    flags[POS_COUNT_DONE] = countDone_q;
    flags[POS_BUFFERS_EXHAUSTED] = (rxCount_q == COUNT_ZERO) && (rxNext_q == COUNT_ZERO); // R07
  end

  // Unmapped and write-only offsets read as zero.
  always_comb
  begin
    rdata_d = RESET_WORD; // R16
    if (bus.read)
    begin
      case (bus.addr)
        OFF_CHAN_ENABLED: rdata_d[NUM_CHANNELS-1:0] = chanEnabled; // R01
        OFF_FLAG_STATUS: rdata_d[FLAG_WIDTH-1:0] = flags;
        OFF_LATEST_RESULT: rdata_d[RESULT_WIDTH-1:0] = latest_q;
        OFF_IRQ_ENABLE_READBACK: rdata_d[FLAG_WIDTH-1:0] = mask_q; // R12
        OFF_DMA_RECEIVE_COUNTER: rdata_d[COUNT_WIDTH-1:0] = rxCount_q;
        OFF_DMA_NEXT_RECEIVE_COUNTER: rdata_d[COUNT_WIDTH-1:0] = rxNext_q;
        default:
        begin
          if (inResultWindow(bus.addr))
          begin
            rdata_d[RESULT_WIDTH-1:0] = chanResult_q[3'(bus.addr[4:2] - 3'h4)];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdata <= RESET_WORD;
    end
    else
    begin
      rdata <= rdata_d;
    end
  end

  // The request follows the registered flags one cycle behind them.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(flags & mask_q); // R15
    end
  end

endmodule // acsr_status_regs

// ### bench/acsr_status_regs_properties.sv
/* Checker for the status register block, watching only its ports.
   Assumes the acsr_pkg offsets and the bench's one-idle-cycle gap between accesses. */
`timescale 1ns/100ps
module acsr_status_regs_properties
  import acsr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire acsr_pkg::acsr_bus_t bus,
  input wire logic [31:0] rdata,
  input wire logic [7:0] chanEnabled,
  input wire acsr_pkg::acsr_conv_t conv,
  input wire logic overrunGeneral,
  input wire acsr_pkg::acsr_dma_t dma,
  input wire logic irq
);
  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire logic stRd = bus.read && bus.addr == OFF_FLAG_STATUS;
  wire logic latRd = bus.read && bus.addr == OFF_LATEST_RESULT;
  wire logic imrRd = bus.read && bus.addr == OFF_IRQ_ENABLE_READBACK;
  wire logic ierWr = bus.write && bus.addr == OFF_IRQ_SET_ENABLE;
  wire logic idrWr = bus.write && bus.addr == OFF_IRQ_CLEAR_ENABLE;
  wire logic quiet = !conv.done && !overrunGeneral;
  wire logic cntWr = bus.write && !dma.transfer && (bus.addr == OFF_DMA_RECEIVE_COUNTER
    || bus.addr == OFF_DMA_NEXT_RECEIVE_COUNTER);
  sequence convThenLatest;
    conv.done ##1 !conv.done ##1 (latRd && !conv.done);
  endsequence
  sequence twoStatusReads;
    (stRd && quiet) ##1 quiet ##1 (stRd && quiet);
  endsequence
  chan_readback_a: assert property (bus.read && bus.addr == OFF_CHAN_ENABLED |=>
    rdata == {24'h0, $past(chanEnabled)}) else $error("channel readback wrong");
  latest_value_a: assert property (convThenLatest |=>
    rdata == {22'h0, $past(conv.value, 3)}) else $error("latest result wrong");
  valid_flag_a: assert property (conv.done ##1 !latRd ##1 stRd |=>
    rdata[POS_DATA_VALID]) else $error("data valid flag not set");
  overrun_clear_a: assert property (twoStatusReads |=>
    rdata[15:8] == 8'h00 && !rdata[POS_ANY_OVERRUN])
    else $error("overrun flags survive a status read");
  mask_set_a: assert property (ierWr ##1 !bus.write ##1 imrRd |=>
    (rdata & $past(bus.wdata, 3) & 32'h000F_FFFF) == ($past(bus.wdata, 3) & 32'h000F_FFFF))
    else $error("enable write did not set mask");
  mask_clear_a: assert property (idrWr ##1 !bus.write ##1 imrRd |=>
    (rdata & $past(bus.wdata, 3)) == 32'h0) else $error("disable write did not clear mask");
  irq_off_a: assert property ((idrWr && bus.wdata[19:0] == 20'hFFFFF) ##1 !ierWr |=> !irq)
    else $error("irq high with all sources masked");
  count_clear_a: assert property (cntWr ##1 !dma.transfer ##1 (stRd && !dma.transfer) |=>
    !rdata[POS_COUNT_DONE]) else $error("count done survives counter write");
endmodule // acsr_status_regs_properties

bind acsr_status_regs acsr_status_regs_properties acsr_status_regs_properties_i (.clk(clk),
  .rst(rst), .bus(bus), .rdata(rdata), .chanEnabled(chanEnabled), .conv(conv),
  .overrunGeneral(overrunGeneral), .dma(dma), .irq(irq));

// ### bench/acsr_far_model.sv
/* Far-side model: converter core done pulses, general overrun and DMA transfers.
   Assumes the bench calls one task at a time from a single process. */
`timescale 1ns/100ps
module acsr_far_model
  import acsr_pkg::*;
(
  input wire logic clk,
  output acsr_pkg::acsr_conv_t conv,
  output logic overrunGeneral,
  output acsr_pkg::acsr_dma_t dma
);
  // ==========================================================================
  // Pulse drivers
  // ==========================================================================
  initial
  begin
    conv = '{1'b0, 3'h7, 10'h3FF};
    overrunGeneral = 1'b0;
    dma = '0;
  end
  // Channel and value lines show the inverse between pulses so stale data is never reused.
  task automatic convert(input logic [2:0] ch, input logic [9:0] val);
    @(posedge clk);
    conv <= '{1'b1, ch, val};
    @(posedge clk);
    conv <= '{1'b0, ~ch, ~val};
  endtask
  task automatic pulseOverrun();
    @(posedge clk);
    overrunGeneral <= 1'b1;
    @(posedge clk);
    overrunGeneral <= 1'b0;
  endtask
  task automatic transfer();
    @(posedge clk);
    dma <= '{transfer: 1'b1};
    @(posedge clk);
    dma <= '0;
  endtask
endmodule // acsr_far_model

// ### bench/acsr_status_regs_tb_top.sv
/* Directed bench for the status register block using register access tasks.
   Assumes the far-side model drives the converter and DMA inputs. */
`timescale 1ns/100ps
module acsr_status_regs_tb_top;
  import acsr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  acsr_bus_t bus = '0;
  logic [31:0] rdata;
  logic [7:0] chanEnabled = 8'hA5;
  acsr_conv_t conv;
  logic overrunGeneral;
  acsr_dma_t dma;
  logic irq;
  int nMismatch = 0;
  int nTests = 0;
  acsr_status_regs acsr_status_regs_i (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
    .chanEnabled(chanEnabled), .conv(conv), .overrunGeneral(overrunGeneral), .dma(dma),
    .irq(irq));
  acsr_far_model acsr_far_model_i (.clk(clk), .conv(conv), .overrunGeneral(overrunGeneral),
    .dma(dma));
  // ==========================================================================
  // Access and compare tasks
  // ==========================================================================
  initial
  begin
    forever #5 clk = ~clk;
  end
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    nTests++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 cmp($sformatf("reg %h", a), exp, rdata);
  endtask
  task automatic irqIs(input logic e);
    repeat (2) @(posedge clk);
    #1 cmp("irq", {31'h0, e}, {31'h0, irq});
  endtask
  task automatic endOfTest();
    if (nMismatch == 0 && nTests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    #100000;
    nMismatch++;
    endOfTest();
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(OFF_FLAG_STATUS, 32'h0008_0000);
    rd(OFF_IRQ_ENABLE_READBACK, 32'h0);
    rd(8'h5C, 32'h0);
    rd(OFF_CHAN_ENABLED, 32'h0000_00A5);
    for (int i = 0; i < 8; i++)
    begin
      acsr_far_model_i.convert(i[2:0], 10'h200 + 10'(i));
      rd(OFF_LATEST_RESULT, 32'h200 + i);
    end
    acsr_far_model_i.convert(3'h0, 10'h155);
    acsr_far_model_i.convert(3'h0, 10'h2AA);
    rd(OFF_FLAG_STATUS, 32'h000B_01A5);
    rd(OFF_FLAG_STATUS, 32'h0009_00A5);
    rd(OFF_LATEST_RESULT, 32'h0000_02AA);
    for (int i = 0; i < 8; i++)
      rd(OFF_CHAN_RESULT_BASE + 8'(4 * i),
        !chanEnabled[i] ? 32'h0 : i == 0 ? 32'h2AA : 32'h200 + i);
    wr(OFF_IRQ_SET_ENABLE, 32'hFFFF_FFFF);
    rd(OFF_IRQ_ENABLE_READBACK, 32'h000F_FFFF);
    irqIs(1'b1);
    wr(OFF_IRQ_SET_ENABLE, 32'h0);
    rd(OFF_IRQ_ENABLE_READBACK, 32'h000F_FFFF);
    wr(OFF_IRQ_CLEAR_ENABLE, 32'h000F_FFFF);
    rd(OFF_IRQ_ENABLE_READBACK, 32'h0);
    irqIs(1'b0);
    wr(OFF_IRQ_SET_ENABLE, 32'h0002_0000);
    irqIs(1'b0);
    acsr_far_model_i.pulseOverrun();
    irqIs(1'b1);
    rd(OFF_FLAG_STATUS, 32'h000A_00A5);
    irqIs(1'b0);
    @(posedge clk);
    chanEnabled <= 8'h00;
    rd(OFF_FLAG_STATUS, 32'h0008_0000);
    rd(OFF_CHAN_ENABLED, 32'h0);
    acsr_far_model_i.convert(3'h3, 10'h0F0);
    rd(OFF_CHAN_RESULT_BASE + 8'h0C, 32'h0);
    rd(OFF_LATEST_RESULT, 32'h0F0);
    wr(OFF_DMA_RECEIVE_COUNTER, 32'h2);
    wr(OFF_DMA_NEXT_RECEIVE_COUNTER, 32'h1);
    rd(OFF_FLAG_STATUS, 32'h0);
    repeat (2) acsr_far_model_i.transfer();
    rd(OFF_FLAG_STATUS, 32'h0004_0000);
    rd(OFF_DMA_RECEIVE_COUNTER, 32'h1);
    repeat (2) acsr_far_model_i.transfer();
    rd(OFF_FLAG_STATUS, 32'h000C_0000);
    wr(OFF_DMA_NEXT_RECEIVE_COUNTER, 32'h0);
    rd(OFF_FLAG_STATUS, 32'h0008_0000);
    endOfTest();
  end
endmodule // acsr_status_regs_tb_top
